// >>> design/pic_top.sv
// Prioritized interrupt controller with APB register slave
//
// Implementation choices: the APB register port and the register addresses.
`include "pic_params.svh"
`default_nettype none
module pic_top #(
    parameter int NSRC = 64
) (
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    // APB slave
    input  wire pic_pkg::pic_apb_req_t  apb_i,
    output logic [31:0]                 prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // Request sources, asynchronous pins
    input  wire logic [NSRC-1:0]        irq_i,
    // Core side
    output pic_pkg::pic_core_req_t      core_req_o,
    output logic                        boot_drive_o,
    // System integration wake notice
    output logic                        wake_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        pic_pkg::pic_phase_t   phase;
        logic [NSRC-1:0]       sync1;
        logic [NSRC-1:0]       sync2;
        logic [2*NSRC-1:0]     prio;     // two bits per source
        logic [NSRC-1:0]       ena;
        logic [NSRC-1:0]       ena_snap; // enables frozen at sleep entry
        logic                  sleep;
        logic [15:0]           vbase;
        logic [5:0]            fm0;
        logic [5:0]            fm1;
        logic [15:0]           fvl0;
        logic [4:0]            fvh0;
        logic [15:0]           fvl1;
        logic [4:0]            fvh1;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  slverr;
        pic_pkg::pic_core_req_t req;
        logic                  boot;
        logic                  wake;
    } pic_state_t;

    pic_state_t st;
    pic_state_t next_st;

    // ****************************************************************
    // Per-level request vectors
    // ****************************************************************
    // Each source has a two-bit level, 3 highest and 0 lowest, gated by its
    // enable bit. Only sources with a field in the priority words can be
    // moved; the rest sit at a fixed level that software cannot change.
    // A disabled source never reaches any level vector.
    // Count of sources with a programmable level field
    localparam int NPROG = 8 * (`PIC_IDX_PRIO_LAST + 1);
    logic [NSRC-1:0] act;
    logic [NSRC-1:0] lvl_req [4];
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++)
        begin : g_src
            logic [1:0] lvl;
            if (gi < NPROG)
            begin : g_prog
                assign lvl = st.prio[2*gi +: 2];
            end
            else
            begin : g_fixed
                assign lvl = `PIC_LVL_FIXED;
            end
            assign act[gi] = st.sync2[gi] & st.ena[gi];
            assign lvl_req[0][gi] = act[gi] && lvl == 2'd0;
            assign lvl_req[1][gi] = act[gi] && lvl == 2'd1;
            assign lvl_req[2][gi] = act[gi] && lvl == 2'd2;
            assign lvl_req[3][gi] = act[gi] && lvl == 2'd3;
        end
    endgenerate

    // Lowest set index of a request vector
    // Scans from the top down, so the last hit kept is the lowest index
    function automatic logic [5:0] pic_lowest(input logic [NSRC-1:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 6'(i);
            end
        end
        return r;
    endfunction : pic_lowest

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic        acc;
    logic [7:0]  idx;
    logic [1:0]  win_lvl;
    logic        win_any;
    logic [5:0]  win_vec;
    logic [NSRC-1:0] wake_src;
    logic [31:0] rd;

    always_comb
    begin
        next_st = st;
        acc     = apb_i.psel && apb_i.penable && !st.ready;
        idx     = apb_i.paddr[9:2];
        rd      = 32'h0000_0000;
        // Two-flop synchroniser on the pins; only the second stage feeds the
        // arbiter, so a metastable first stage never reaches any decision
        next_st.sync1 = irq_i;
        next_st.sync2 = st.sync1;

        // Highest level first, lowest source inside it
        // Levels are tried in a fixed order, so there is never a tie
        win_any = 1'b1;
        win_lvl = 2'd3;
        if (|lvl_req[3])
        begin
            win_lvl = 2'd3;
        end
        else if (|lvl_req[2])
        begin
            win_lvl = 2'd2;
        end
        else if (|lvl_req[1])
        begin
            win_lvl = 2'd1;
        end
        else if (|lvl_req[0])
        begin
            win_lvl = 2'd0;
        end
        else
        begin
            win_any = 1'b0;
        end
        win_vec = pic_lowest(lvl_req[win_lvl]);

        // Presented request: level, vector, address
        // Valid, level, vector and address all move on one edge
        next_st.req.valid  = win_any;
        next_st.req.level  = win_lvl;
        next_st.req.vector = win_vec;
        next_st.req.fast   = 1'b0;
        // Base joined with the number, one table slot per source
        next_st.req.addr   = 21'({st.vbase[13:0], 1'b0, win_vec});
        // Fast match found here, so the core already sees the full address
        // Channel 0 is tried first when both hold the same number
        if (win_any && win_lvl == `PIC_LVL2 && win_vec == st.fm0)
        begin
            next_st.req.fast = 1'b1;
            next_st.req.addr = {st.fvh0, st.fvl0};
        end
        else if (win_any && win_lvl == `PIC_LVL2 && win_vec == st.fm1)
        begin
            next_st.req.fast = 1'b1;
            next_st.req.addr = {st.fvh1, st.fvl1};
        end

        // Wake notice: while asleep only enables from before entry count
        // The snapshot keeps an enable written while asleep from waking clocks
        wake_src     = st.sleep ? (st.sync2 & st.ena_snap) : act;
        next_st.wake = |wake_src;

        // Boot: drive the fetch address one cycle, then run
        // Valid stays low so the core never takes the boot address as a vector
        unique case (st.phase)
            pic_pkg::PIC_BOOT:
            begin
                next_st.boot     = 1'b1;
                next_st.req.addr = `PIC_BOOT_ADDR;
                next_st.req.valid = 1'b0;
                next_st.phase    = pic_pkg::PIC_RUN;
            end
            pic_pkg::PIC_RUN:
            begin
                next_st.boot = 1'b0;
            end
            default:
            begin
                next_st.phase = pic_pkg::PIC_BOOT;
            end
        endcase

        // APB read mux
        // Unmapped words read as zero; their error flag is formed below
        if (idx <= `PIC_IDX_PRIO_LAST)
        begin
            rd[15:0] = st.prio[16*idx[2:0] +: 16];
        end
        else if (idx == `PIC_IDX_VBASE)
        begin
            rd[15:0] = st.vbase;
        end
        else if (idx == `PIC_IDX_FM0)
        begin
            rd[5:0] = st.fm0;
        end
        else if (idx == `PIC_IDX_FVL0)
        begin
            rd[15:0] = st.fvl0;
        end
        else if (idx == `PIC_IDX_FVH0)
        begin
            rd[4:0] = st.fvh0;
        end
        else if (idx == `PIC_IDX_FM1)
        begin
            rd[5:0] = st.fm1;
        end
        else if (idx == `PIC_IDX_FVL1)
        begin
            rd[15:0] = st.fvl1;
        end
        else if (idx == `PIC_IDX_FVH1)
        begin
            rd[4:0] = st.fvh1;
        end
        else if (idx >= `PIC_IDX_PEND0 && idx <= `PIC_IDX_PEND3)
        begin
            // Pending word k shows sources 16k to 16k+15 after their enables
            rd[15:0] = act[16*(idx - `PIC_IDX_PEND0) +: 16];
        end
        else if (idx == `PIC_IDX_CTRL)
        begin
            // Presented level code, shows core-visible state
            // Levels 2 and 3 share one code, the core needs no finer split
            rd[`PIC_CTRL_LVL_LSB +: 2] = !st.req.valid ? 2'b00 :
                (st.req.level == 2'd3) ? 2'b11 :
                (st.req.level == 2'd2) ? 2'b11 :
                (st.req.level == 2'd1) ? 2'b10 : 2'b01;
            rd[`PIC_CTRL_VEC_LSB +: 6]   = st.req.vector;
            rd[`PIC_CTRL_SLEEP_BIT]      = st.sleep;
        end
        else if (idx >= `PIC_IDX_ENA0 && idx <= `PIC_IDX_ENA3)
        begin
            rd[15:0] = st.ena[16*idx[1:0] +: 16];
        end

        // APB access: ready is a one-cycle pulse one edge into the access
        // phase; the !ready term in acc keeps a held phase from acting twice
        next_st.ready  = acc;
        next_st.slverr = 1'b0;
        next_st.rdata  = rd;
        // Writes land on the edge that raises ready; pending words ignore them
        if (acc && apb_i.pwrite)
        begin
            if (idx <= `PIC_IDX_PRIO_LAST)
            begin
                next_st.prio[16*idx[2:0] +: 16] = apb_i.pwdata[15:0];
            end
            else if (idx == `PIC_IDX_VBASE)
            begin
                next_st.vbase = apb_i.pwdata[15:0] & `PIC_VBASE_MASK;
            end
            else if (idx == `PIC_IDX_FM0)
            begin
                next_st.fm0 = apb_i.pwdata[5:0];
            end
            else if (idx == `PIC_IDX_FVL0)
            begin
                next_st.fvl0 = apb_i.pwdata[15:0];
            end
            else if (idx == `PIC_IDX_FVH0)
            begin
                next_st.fvh0 = apb_i.pwdata[4:0];
            end
            else if (idx == `PIC_IDX_FM1)
            begin
                next_st.fm1 = apb_i.pwdata[5:0];
            end
            else if (idx == `PIC_IDX_FVL1)
            begin
                next_st.fvl1 = apb_i.pwdata[15:0];
            end
            else if (idx == `PIC_IDX_FVH1)
            begin
                next_st.fvh1 = apb_i.pwdata[4:0];
            end
            else if (idx == `PIC_IDX_CTRL)
            begin
                // Freeze enables at sleep entry so later writes cannot wake
                next_st.sleep = apb_i.pwdata[`PIC_CTRL_SLEEP_BIT];
                if (apb_i.pwdata[`PIC_CTRL_SLEEP_BIT] && !st.sleep)
                begin
                    next_st.ena_snap = st.ena;
                end
            end
            else if (idx >= `PIC_IDX_ENA0 && idx <= `PIC_IDX_ENA3)
            begin
                next_st.ena[16*idx[1:0] +: 16] = apb_i.pwdata[15:0];
            end
            else if (!(idx >= `PIC_IDX_PEND0 && idx <= `PIC_IDX_PEND3))
            begin
                next_st.slverr = 1'b1;
            end
        end
        else if (acc)
        begin
            // A read of an unmapped word answers with the error flag and zero
            next_st.slverr = !((idx <= `PIC_IDX_FVH1) || idx == `PIC_IDX_CTRL
                || (idx >= `PIC_IDX_PEND0 && idx <= `PIC_IDX_PEND3)
                || (idx >= `PIC_IDX_ENA0 && idx <= `PIC_IDX_ENA3));
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Asynchronous clear; the vector base keeps its own reset constant
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st       <= '0;
            st.vbase <= `PIC_VBASE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    // Every port is a plain wire of the state register, no logic after it
    assign prdata_o     = st.rdata;
    assign pready_o     = st.ready;
    assign pslverr_o    = st.slverr;
    assign core_req_o   = st.req;
    assign boot_drive_o = st.boot;
    assign wake_o       = st.wake;
endmodule : pic_top
`default_nettype wire

// >>> design/pic_params.svh
// Constants of the prioritized interrupt controller: offsets, fields, resets
// Notes on behaviour
// - Sixty-four request sources each get one of four priority levels, some fixed.
// - Within one level the lowest-numbered active source wins.
// - A pending request of enough priority is signalled to the core with its address.
// - Normal vector address is the vector base joined with the vector number.
// - A two-bit field shows the presented level: 00 none, 01 lvl0, 10 lvl1, 11 lvl2/3.
// - Two fast channels each hold a match number and a full vector address.
// - A number matching a fast channel at level 2 makes a fast interrupt.
// - A fast interrupt presents the matching channel's low and high address.
// - The controller detects fast interrupts itself, before the core.
// - A pending request raises a wake notice to the system integration logic.
// - After reset the controller drives the initial fetch address.
// - Registers are reached as a slave of the peripheral bus.
// - In wait or stop only requests enabled before entry raise the wake notice.
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
// ****************************************************************
// Register word indices; the byte address is the index times four
// ****************************************************************
`define PIC_IDX_PRIO0      8'h00
`define PIC_IDX_PRIO_LAST  8'h06
`define PIC_IDX_VBASE      8'h07
`define PIC_IDX_FM0        8'h08
`define PIC_IDX_FVL0       8'h09
`define PIC_IDX_FVH0       8'h0A
`define PIC_IDX_FM1        8'h0B
`define PIC_IDX_FVL1       8'h0C
`define PIC_IDX_FVH1       8'h0D
`define PIC_IDX_PEND0      8'h0E
`define PIC_IDX_PEND3      8'h11
`define PIC_IDX_CTRL       8'h16
`define PIC_IDX_ENA0       8'h18
`define PIC_IDX_ENA3       8'h1B
// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define PIC_VBASE_MASK     16'h3FFF
`define PIC_FM_MASK        16'h003F
`define PIC_FVH_MASK       16'h001F
`define PIC_CTRL_SLEEP_BIT 0
`define PIC_CTRL_LVL_LSB   14
`define PIC_CTRL_VEC_LSB   4
`define PIC_VBASE_RST      16'h0000
`define PIC_BOOT_ADDR      21'h00_0000
`define PIC_LVL2           2'h2
`define PIC_LVL_FIXED      2'h0
`endif

// >>> design/pic_pkg.sv
// Types of the prioritized interrupt controller
`default_nettype none
package pic_pkg;
    // APB request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pic_apb_req_t;

    // Reset sequencing state, Gray coded
    typedef enum logic [1:0] {
        PIC_BOOT = 2'b00,
        PIC_RUN  = 2'b01
    } pic_phase_t;

    // Interrupt request seen by the core
    typedef struct packed {
        logic        valid;
        logic [1:0]  level;
        logic        fast;
        logic [5:0]  vector;
        logic [20:0] addr;
    } pic_core_req_t;
endpackage : pic_pkg
`default_nettype wire

// >>> verif/pic_top_assertions.sv
// Port-level assertions of the prioritized interrupt controller
`default_nettype none
module pic_top_assertions #(
    parameter int NSRC = 64
) (
    // Clock and reset
    input wire logic                   sys_clk_i,
    input wire logic                   rst_n_i,
    // Register bus
    input wire pic_pkg::pic_apb_req_t  apb_i,
    input wire logic [31:0]            prdata_o,
    input wire logic                   pready_o,
    input wire logic                   pslverr_o,
    // Sources and core side
    input wire logic [NSRC-1:0]        irq_i,
    input wire pic_pkg::pic_core_req_t core_req_o,
    input wire logic                   boot_drive_o,
    input wire logic                   wake_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Bus answer timing and error form
    one_wait_a: assert property (apb_i.psel && apb_i.penable && !pready_o |=> pready_o)
        else $error("bus answer missing after one wait state");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    ready_cause_a: assert property (pready_o |-> $past(apb_i.psel && apb_i.penable))
        else $error("ready without an access phase");
    err_form_a: assert property (pslverr_o |-> pready_o && prdata_o == '0)
        else $error("error answer malformed");
    // Boot address right after reset, for one cycle only
    boot_rise_a: assert property ($rose(rst_n_i) |=> boot_drive_o)
        else $error("boot address not driven after reset");
    boot_once_a: assert property (boot_drive_o |-> (!core_req_o.valid && core_req_o.addr == '0)
        ##1 !boot_drive_o)
        else $error("boot drive malformed");
    // Request shape; a fast request is always level two
    fast_lvl_a: assert property (core_req_o.fast |-> core_req_o.valid && core_req_o.level == 2'h2)
        else $error("fast request not at level two");
    norm_addr_a: assert property (core_req_o.valid && !core_req_o.fast
        |-> core_req_o.addr[6:0] == {1'b0, core_req_o.vector})
        else $error("normal address not base joined with vector");
    // Quiet pins leave core and wake quiet after the sync delay
    quiet_core_a: assert property ((irq_i == '0) [*3] |=> !core_req_o.valid && !wake_o)
        else $error("request presented with no source active");
    req_cause_a: assert property ($rose(core_req_o.valid) |-> $past(irq_i != '0, 3))
        else $error("request rose without an active source");
    // Main scenarios reached
    c_fast: cover property (core_req_o.fast);
    c_err: cover property (pslverr_o);
    c_wake: cover property (wake_o);
    c_boot: cover property (boot_drive_o);
endmodule : pic_top_assertions

bind pic_top pic_top_assertions #(.NSRC(NSRC)) pic_top_assertions_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_i(irq_i), .core_req_o(core_req_o),
    .boot_drive_o(boot_drive_o), .wake_o(wake_o));
`default_nettype wire

// >>> verif/pic_core_model.sv
// Behavioural model of the core's interrupt acceptance
`default_nettype none
module pic_core_model (
    // Request from the controller
    input  wire pic_pkg::pic_core_req_t core_req_i,
    // Core mask bits and kind of fetched word
    input  wire logic [1:0]             mask_i,
    input  wire logic                   fetched_jump_i,
    // Acceptance
    output logic                        take_o,
    output logic                        fast_go_o
);
    // Levels below the mask value are held off
    assign take_o    = core_req_i.valid && (core_req_i.level >= mask_i);
    // A jump at the fast vector falls back to normal handling
    assign fast_go_o = take_o && core_req_i.fast && !fetched_jump_i;
endmodule : pic_core_model
`default_nettype wire

// >>> verif/pic_bench.sv
// Self-checking bench of the prioritized interrupt controller
`include "pic_params.svh"
`default_nettype none
module pic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus, observed outputs and bookkeeping
    logic                   clk;
    logic                   rst_n;
    pic_pkg::pic_apb_req_t  apb;
    logic [63:0]            irq;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    pic_pkg::pic_core_req_t creq;
    logic                   boot;
    logic                   wake;
    logic [1:0]             mask;
    logic                   jump;
    logic                   take;
    logic                   fast_go;
    logic [15:0]            pr [7];
    logic [31:0]            rd;
    logic                   er;
    int                     n_errors;
    int                     check_count;
    int                     cyc;

    pic_top pic_top_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .apb_i(apb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_i(irq), .core_req_o(creq),
        .boot_drive_o(boot), .wake_o(wake));
    pic_core_model pic_core_model_inst (.core_req_i(creq), .mask_i(mask),
        .fetched_jump_i(jump), .take_o(take), .fast_go_o(fast_go));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready seen at an edge
    task automatic apb_xfer(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: {2'b00, idx, 2'b00}, pwdata: wd};
        @(posedge clk);
        apb.penable <= 1'b1;
        @(posedge clk iff pready);
        rd = prdata;
        er = pslverr;
        apb <= '0;
    endtask : apb_xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb_xfer(1'b1, idx, d);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb_xfer(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdc

    // Keeps a shadow of the two-bit priority fields
    task automatic set_prio(input int src, input logic [1:0] lvl);
        pr[src / 8][2 * (src % 8) +: 2] = lvl;
        wr(8'(src / 8), {16'h0000, pr[src / 8]});
    endtask : set_prio

    // Pins pass two sync flops and the arbiter register before showing
    task automatic drive_irq(input logic [63:0] v);
        @(posedge clk);
        irq <= v;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : drive_irq

    function automatic logic [31:0] exp_req(input logic [1:0] l, input logic f,
                                            input logic [5:0] v, input logic [20:0] a);
        return {1'b0, 1'b1, l, f, v, a};
    endfunction : exp_req

    task automatic s_regs();
        wr(`PIC_IDX_VBASE, 32'hFFFF_FFFF);
        rdc(`PIC_IDX_VBASE, 32'h0000_3FFF);
        wr(`PIC_IDX_FM1, 32'hFFFF_FFFF);
        rdc(`PIC_IDX_FM1, 32'h0000_003F);
        wr(`PIC_IDX_FVH0, 32'hFFFF_FFFF);
        rdc(`PIC_IDX_FVH0, 32'h0000_001F);
        rdc(8'h3F, 32'h0000_0000);
        chk(er, 32'h0000_0001);
        wr(`PIC_IDX_PEND0, 32'hFFFF_FFFF);
        chk(er, 32'h0000_0000);
    endtask : s_regs

    task automatic s_arb();
        logic [1:0] code;
        for (int k = 0; k < 4; k++)
            wr(8'(`PIC_IDX_ENA0 + k), 32'h0000_FFFF);
        wr(`PIC_IDX_VBASE, 32'h0000_2ABC);
        for (int l = 0; l < 4; l++)
        begin
            set_prio(7, 2'(l));
            drive_irq(64'h1 << 7);
            chk(creq, exp_req(2'(l), 1'b0, 6'h07, {14'h2ABC, 7'h07}));
            code = (l == 0) ? 2'h1 : (l == 1) ? 2'h2 : 2'h3;
            rdc(`PIC_IDX_CTRL, {16'h0000, code, 4'h0, 6'h07, 4'h0});
        end
        drive_irq(64'h0);
        rdc(`PIC_IDX_CTRL, 32'h0000_0000);
        // Source 63 has no priority field and stays at level 0
        set_prio(0, 2'h3);
        set_prio(5, 2'h1);
        set_prio(9, 2'h1);
        drive_irq(64'h8000_0000_0000_0221);
        chk(creq, exp_req(2'h3, 1'b0, 6'h00, {14'h2ABC, 7'h00}));
        drive_irq(64'h8000_0000_0000_0220);
        chk(creq, exp_req(2'h1, 1'b0, 6'h05, {14'h2ABC, 7'h05}));
        drive_irq(64'h8000_0100_0000_0000);
        chk(creq, exp_req(2'h0, 1'b0, 6'h28, {14'h2ABC, 7'h28}));
        drive_irq(64'h8000_0000_0000_0000);
        chk(creq, exp_req(2'h0, 1'b0, 6'h3F, {14'h2ABC, 7'h3F}));
        mask <= 2'h2;
        @(negedge clk);
        chk(take, 32'h0000_0000);
        wr(`PIC_IDX_ENA0, 32'h0000_FDDF);
        drive_irq(64'h0000_0000_0000_0220);
        chk(creq.valid, 32'h0000_0000);
        wr(`PIC_IDX_ENA0, 32'h0000_FFFF);
    endtask : s_arb

    task automatic s_fast();
        set_prio(20, 2'h2);
        set_prio(30, 2'h2);
        wr(`PIC_IDX_FM0, 32'h0000_0014);
        wr(`PIC_IDX_FVL0, 32'h0000_1234);
        wr(`PIC_IDX_FVH0, 32'h0000_0011);
        wr(`PIC_IDX_FM1, 32'h0000_001E);
        wr(`PIC_IDX_FVL1, 32'h0000_BEEF);
        wr(`PIC_IDX_FVH1, 32'h0000_000A);
        drive_irq(64'h1 << 20);
        chk(creq, exp_req(2'h2, 1'b1, 6'h14, 21'h11_1234));
        chk(fast_go, 32'h0000_0001);
        jump <= 1'b1;
        @(negedge clk);
        chk(fast_go, 32'h0000_0000);
        drive_irq(64'h1 << 30);
        chk(creq, exp_req(2'h2, 1'b1, 6'h1E, 21'h0A_BEEF));
        set_prio(30, 2'h3);
        drive_irq(64'h1 << 30);
        chk(creq, exp_req(2'h3, 1'b0, 6'h1E, {14'h2ABC, 7'h1E}));
    endtask : s_fast

    task automatic s_wake();
        drive_irq(64'h0);
        wr(8'(`PIC_IDX_ENA0 + 2), 32'h0000_0000);
        wr(`PIC_IDX_CTRL, 32'h0000_0001);
        drive_irq(64'h1 << 3);
        chk(wake, 32'h0000_0001);
        rdc(`PIC_IDX_CTRL, {16'h0000, 2'h1, 4'h0, 6'h03, 3'h0, 1'b1});
        drive_irq(64'h0);
        wr(8'(`PIC_IDX_ENA0 + 2), 32'h0000_FFFF);
        drive_irq(64'h1 << 40);
        chk(wake, 32'h0000_0000);
        wr(`PIC_IDX_CTRL, 32'h0000_0000);
        drive_irq(64'h1 << 40);
        chk(wake, 32'h0000_0001);
        rdc(8'(`PIC_IDX_PEND0 + 2), 32'h0000_0100);
    endtask : s_wake

    task automatic final_report();
        $display("errors %0d of %0d checks", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // Reset, boot check, then the scenarios
    initial
    begin
        rst_n = 1'b0;
        apb = '0;
        irq = '0;
        mask = 2'h0;
        jump = 1'b0;
        n_errors = 0;
        check_count = 0;
        cyc = 0;
        foreach (pr[k]) pr[k] = 16'h0000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        chk(boot, 32'h0000_0001);
        chk(creq.addr, `PIC_BOOT_ADDR);
        @(negedge clk);
        chk(boot, 32'h0000_0000);
        s_regs();
        s_arb();
        s_fast();
        s_wake();
        final_report();
    end
endmodule : pic_bench
`default_nettype wire
